//--- bench/csbs_far_model.sv
// Far-side model: setup memory checker and serial loopback
`timescale 1ns/1ps
`default_nettype none
module csbs_far_model (
  input  wire logic ref_clk,   // Controller clock
  input  wire logic ee_start,  // Memory check request
  input  wire logic ser_start, // Transmission request
  input  wire logic ok_cfg,    // Result the memory reports
  output logic      ee_done,   // One-cycle done
  output logic      ee_ok,     // Valid only with ee_done
  output logic      ser_done   // Looped frame returned
);
  // ----------------------------------------------------------------
  // Countdowns
  // ----------------------------------------------------------------
  logic [3:0] ee_cnt  = 4'h0;  // Memory busy countdown
  logic [3:0] ser_cnt = 4'h0;  // Frame in flight countdown
  logic       junk    = 1'b0;  // Stale result must never look valid
  // Check answers a few cycles after its start
  always @(posedge ref_clk) begin
    junk    <= ~junk;
    ee_cnt  <= ee_start ? 4'h5 : (ee_cnt != 4'h0 ? ee_cnt - 4'h1 : 4'h0);
    ser_cnt <= ser_start ? 4'h3 : (ser_cnt != 4'h0 ? ser_cnt - 4'h1 : 4'h0);
  end
  assign ee_done  = (ee_cnt == 4'h1);
  // Outside its done cycle the result line toggles
  assign ee_ok    = ee_done ? ok_cfg : junk;
  // No serial wires: ser_done rises three cycles after ser_start
  assign ser_done = (ser_cnt == 4'h1);
endmodule
`default_nettype wire

//--- bench/csbs_sequencer_tb_top.sv
// Self-checking bench for the charge bank sequencer
`timescale 1ns/1ps
`default_nettype none
module csbs_sequencer_tb_top;
  import csbs_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int unsigned TDIV = 8;  // Short second keeps run brief
  localparam logic [3:0] BK [9] = '{4'hf, 4'h7, 4'h3, 4'h1, 4'h0,
                                    4'h1, 4'h3, 4'h7, 4'hf};
  logic       ref_clk = 1'b0;
  logic       rstn = 1'b0;
  logic       batt_high = 1'b0;
  logic       batt_low = 1'b0;
  logic       accel_test = 1'b0;
  logic [7:0] change_delay_s = 8'h02;
  logic       key_cal = 1'b0;
  logic       key_inc = 1'b0;
  logic       decrement_key = 1'b0;
  logic [6:0] alarm_in = 7'h00;
  logic       ok_cfg = 1'b1;
  logic       ee_done, ee_ok, ser_done, ex_paused, load_on;
  logic       ee_start, ee_pass, ee_fail, ser_start;
  logic [3:0] bank_on, reg_state;
  logic [7:0] alarm_byte;
  csbs_ex_t   ex_step;
  int         miscompares = 0;
  int         cmp_count = 0;
  int         seed, n, i, dly;
  logic [7:0] q_st[$];        // Expected regulator states
  logic [7:0] q_bk[$];        // Expected bank patterns
  csbs_ex_t   q_ex[$];        // Expected exercise steps
  bit         mon_bank = 1'b1; // Bank watcher enable
  logic [3:0] p_st = 4'h0;
  logic [3:0] p_bk = 4'hf;
  csbs_ex_t   p_ex = EX_OFF;
  logic [7:0] e8;              // Oldest note taken off a queue
  csbs_ex_t   e_ex;            // Oldest step note
  logic [3:0] n_ee = 4'h0;     // Memory check start pulses seen
  logic [3:0] n_ser = 4'h0;    // Transmission start pulses seen

  always #20 ref_clk = ~ref_clk;

  csbs_sequencer #(.TICK_DIV(TDIV)) dut_u (
    .ref_clk(ref_clk), .rstn(rstn), .batt_high(batt_high),
    .batt_low(batt_low), .accel_test(accel_test),
    .change_delay_s(change_delay_s), .key_cal(key_cal),
    .key_inc(key_inc), .decrement_key(decrement_key),
    .alarm_in(alarm_in), .ee_done(ee_done), .ee_ok(ee_ok),
    .ser_done(ser_done), .bank_on(bank_on), .reg_state(reg_state),
    .ex_step(ex_step), .ex_paused(ex_paused), .load_on(load_on),
    .ee_start(ee_start), .ee_pass(ee_pass), .ee_fail(ee_fail),
    .ser_start(ser_start), .alarm_byte(alarm_byte));

  csbs_far_model far_u (
    .ref_clk(ref_clk), .ee_start(ee_start), .ser_start(ser_start),
    .ok_cfg(ok_cfg), .ee_done(ee_done), .ee_ok(ee_ok),
    .ser_done(ser_done));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic final_report;
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk8(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_ex(input string nm, input csbs_ex_t e,
                        input csbs_ex_t g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Inputs always move 2 ns after the rising edge
  task automatic cyc(input int c);
    repeat (c) @(posedge ref_clk);
    #2;
  endtask
  // Key held long enough to pass the pin synchroniser
  task automatic press(input int k);
    key_cal = (k == 0);
    key_inc = (k == 1);
    decrement_key = (k == 2);
    cyc(6);
    {key_cal, key_inc, decrement_key} = 3'h0;
    cyc(6);
  endtask
  // Bounded waits; n returns edges spent
  task automatic wait_st(input logic [3:0] s);
    n = 0;
    while (reg_state !== s && n < 400) begin
      cyc(1);
      n++;
    end
    if (n >= 400) chk8("reg_state wait", {4'h0, s}, {4'h0, reg_state});
  endtask
  task automatic wait_ex(input csbs_ex_t s);
    n = 0;
    while (ex_step !== s && n < 2000) begin
      cyc(1);
      n++;
    end
    if (n >= 2000) chk_ex("ex_step wait", s, ex_step);
  endtask
  task automatic expect_st(input int s, input bit bk);
    q_st.push_back(8'(s));
    if (bk) q_bk.push_back({4'h0, BK[s]});
  endtask

  // ----------------------------------------------------------------
  // Result watcher: each change takes the oldest note
  // ----------------------------------------------------------------
  always @(negedge ref_clk) begin
    if (rstn && reg_state !== p_st) begin
      e8 = q_st.size() != 0 ? q_st.pop_front() : 8'hee;
      chk8("reg_state", e8, {4'h0, reg_state});
    end
    if (rstn && mon_bank && bank_on !== p_bk) begin
      e8 = q_bk.size() != 0 ? q_bk.pop_front() : 8'hee;
      chk8("bank_on", e8, {4'h0, bank_on});
    end
    if (rstn && ex_step !== p_ex) begin
      e_ex = q_ex.size() != 0 ? q_ex.pop_front() : csbs_ex_t'(6'h3f);
      chk_ex("ex_step", e_ex, ex_step);
    end
    // Start pulses last one cycle, so each is counted once
    n_ee = n_ee + {3'h0, ee_start};
    n_ser = n_ser + {3'h0, ser_start};
    p_st = reg_state;
    p_bk = bank_on;
    p_ex = ex_step;
  end

  // Watchdog well beyond the expected run of about 1200 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    final_report();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h94bac5ab;
    dly = 2 + ($random(seed) & 3);
    change_delay_s = 8'(dly);
    cyc(10);
    rstn = 1'b1;
    cyc(1);
    chk8("bank_on", 8'h0f, {4'h0, bank_on});
    chk8("reg_state", 8'h00, {4'h0, reg_state});
    chk_ex("ex_step", EX_OFF, ex_step);
    for (i = 0; i < 3; i++) begin
      alarm_in = 7'($random(seed));
      cyc(5);
      chk8("alarm_byte", {1'b0, alarm_in}, alarm_byte);
    end
    // Both voltage flags: no move expected
    {batt_high, batt_low} = 2'h3;
    cyc(40);
    batt_low = 1'b0;
    for (i = 1; i <= 4; i++) expect_st(i, 1'b1);
    wait_st(4'h1);
    wait_st(4'h2);
    chk8("boost gap", 8'h01, 8'(n >= dly * 8 - 8 && n <= dly * 8 + 3));
    accel_test = 1'b1;
    wait_st(4'h3);
    chk8("accel gap", 8'h01, 8'(n >= 8 && n <= 19));
    wait_st(4'h4);
    chk8("accel gap", 8'h01, 8'(n >= 8 && n <= 19));
    accel_test = 1'b0;
    cyc(30);
    {batt_high, batt_low} = 2'h1;
    // Float up path first: 4, 5, 6 and back to 5
    expect_st(5, 1'b1);
    expect_st(6, 1'b1);
    wait_st(4'h6);
    {batt_high, batt_low} = 2'h2;
    for (i = 5; i <= 8; i++) expect_st(i, 1'b1);
    expect_st(0, 1'b0);
    wait_st(4'h5);
    chk8("float gap", 8'h08, 8'(n));
    {batt_high, batt_low} = 2'h1;
    for (i = 6; i <= 9; i++) begin
      wait_st(4'(i % 9));
      chk8("float gap", 8'h08, 8'(n));
    end
    // Boost down path under accel: up to 2, back to 0
    {batt_high, batt_low, accel_test} = 3'h5;
    for (i = 1; i <= 2; i++) expect_st(i, 1'b1);
    for (i = 1; i >= 0; i--) expect_st(i, 1'b1);
    wait_st(4'h2);
    {batt_high, batt_low} = 2'h1;
    wait_st(4'h1);
    wait_st(4'h0);
    chk8("fall gap", 8'h01, 8'(n >= 8 && n <= 19));
    {batt_low, accel_test} = 2'h0;
    // Let the last bank change reach the watcher before new notes
    cyc(4);
    // Exercise entry after a broken key order
    q_ex = '{EX_BANK, EX_LOAD, EX_EE, EX_WALK, EX_SER, EX_BANK, EX_OFF};
    q_bk = '{8'h1, 8'h2, 8'h4, 8'h8, 8'h0, 8'hf, 8'h7, 8'h3, 8'h1, 8'h0,
             8'h1, 8'h3, 8'h7, 8'hf, 8'h0};
    press(0);
    press(1);
    press(0);
    press(1);
    press(1);
    press(0);
    wait_ex(EX_BANK);
    while (bank_on !== 4'h4 && n < 3000) begin
      cyc(1);
      n++;
    end
    press(1);
    chk8("ex_paused", 8'h01, {7'h0, ex_paused});
    cyc(80);
    chk8("bank held", 8'h04, {4'h0, bank_on});
    press(1);
    chk8("ex_paused", 8'h00, {7'h0, ex_paused});
    wait_ex(EX_WALK);
    chk8("load_on", 8'h01, {7'h0, load_on});
    chk8("ee_pass", 8'h01, {7'h0, ee_pass});
    chk8("ee_fail", 8'h00, {7'h0, ee_fail});
    wait_ex(EX_SER);
    cyc(3);
    mon_bank = 1'b0;
    wait_ex(EX_BANK);
    press(2);
    chk8("ex_paused", 8'h00, {7'h0, ex_paused});
    chk8("bank_on", 8'h0f, {4'h0, bank_on});
    // Second entry with a failing memory
    ok_cfg = 1'b0;
    q_ex = '{EX_BANK, EX_LOAD, EX_EE, EX_WALK, EX_OFF};
    press(0);
    press(1);
    press(1);
    press(0);
    wait_ex(EX_WALK);
    chk8("ee_fail", 8'h01, {7'h0, ee_fail});
    chk8("ee_pass", 8'h00, {7'h0, ee_pass});
    press(2);
    cyc(4);
    n = q_st.size() + q_ex.size() + q_bk.size();
    chk8("pending", 8'h00, 8'(n));
    // Two memory checks started, one transmission
    chk8("start pulses", 8'h21, {n_ee, n_ser});
    final_report();
  end
endmodule
`default_nettype wire

//--- logic/csbs_pkg.sv
// Constants, types and helpers shared by the charge bank sequencer files
package csbs_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;            // 25 MHz ref_clk
  localparam int unsigned SEC_NS        = 1_000_000_000; // One second
  localparam int unsigned TICK_CYCLES   = SEC_NS / CLK_PERIOD_NS;
  localparam logic [7:0]  ACCEL_DELAY_S = 8'h02;         // Test mode delay
  localparam logic [7:0]  DWELL_S       = 8'h04;         // Exercise step
  // ----------------------------------------------------------------
  // Regulator states and bank patterns (bit 0 = bank A, bit 3 = D)
  // ----------------------------------------------------------------
  localparam logic [3:0] ST_ALL_ON  = 4'h0;  // State after reset
  localparam logic [3:0] ST_FLOAT   = 4'h4;  // First float state
  localparam logic [3:0] ST_LAST    = 4'h8;  // Highest state
  localparam logic [3:0] BANKS_ALL  = 4'hf;
  localparam logic [3:0] BANKS_NONE = 4'h0;
  localparam logic [1:0] BANK_IDX_D = 2'h3;  // Last bank tested alone
  localparam int unsigned N_ALARM   = 7;     // Alarm inputs 1..7
  // ----------------------------------------------------------------
  // Exercise steps and key entry sequence (one-hot)
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    EX_OFF  = 6'h01,  // Normal operation
    EX_BANK = 6'h02,  // Charge switch on, one bank at a time
    EX_LOAD = 6'h04,  // Load switched on
    EX_EE   = 6'h08,  // Setup memory write and read check
    EX_WALK = 6'h10,  // Walk every regulator state
    EX_SER  = 6'h20   // Serial transmission
  } csbs_ex_t;
  typedef enum logic [3:0] {
    SQ_IDLE = 4'h1,
    SQ_CAL  = 4'h2,
    SQ_INC1 = 4'h4,
    SQ_INC2 = 4'h8
  } csbs_seq_t;
  // ----------------------------------------------------------------
  // Banks switched on in each regulator state
  // ----------------------------------------------------------------
  function automatic logic [3:0] bank_map(input logic [3:0] st);
    case (st)
      4'h0:    bank_map = 4'hf;  // A B C D
      4'h1:    bank_map = 4'h7;  // D off first
      4'h2:    bank_map = 4'h3;
      4'h3:    bank_map = 4'h1;
      4'h5:    bank_map = 4'h1;  // Float: banks come back from A
      4'h6:    bank_map = 4'h3;
      4'h7:    bank_map = 4'h7;
      4'h8:    bank_map = 4'hf;
      default: bank_map = 4'h0;  // State 4: nothing on
    endcase
  endfunction
endpackage

//--- logic/csbs_sequencer.sv
// Charge bank state sequencer with keypad hardware exercise mode
// How it works
// - Reset enters state 0, all banks on
// - Next state from present state and voltage
// - Boost states move only after change delay
// - Float states change once each second
// - Toward state 4 banks drop from D
// - Increment key pauses and resumes the cycle
// - Decrement key ends exercise mode
// - Each bank tested alone, A to D
// - Alarm byte: input 1 bit 0, active 1
// - Setup memory check gives pass or fail
// - Exercise repeats switch, load, memory, walk, serial
// - Accelerated test shortens delays to two seconds
`timescale 1ns/1ps
`default_nettype none
module csbs_sequencer #(
  parameter int unsigned TICK_DIV = csbs_pkg::TICK_CYCLES
) (
  input  wire logic                  ref_clk,        // 25 MHz clock
  input  wire logic                  rstn,           // Sync reset
  input  wire logic                  batt_high,      // Voltage above band
  input  wire logic                  batt_low,       // Voltage below band
  input  wire logic                  accel_test,     // Short delays
  input  wire logic [7:0]            change_delay_s, // Boost delay
  input  wire logic                  key_cal,        // Calibration key pin
  input  wire logic                  key_inc,        // Increment key pin
  input  wire logic                  decrement_key,  // Decrement key pin
  input  wire logic [csbs_pkg::N_ALARM-1:0] alarm_in, // Alarm pins
  input  wire logic                  ee_done,        // Memory check done
  input  wire logic                  ee_ok,          // Memory check good
  input  wire logic                  ser_done,       // Transmission done
  output logic [3:0]                 bank_on,        // Bank switches
  output logic [3:0]                 reg_state,      // Regulator state
  output csbs_pkg::csbs_ex_t         ex_step,        // Exercise step
  output logic                       ex_paused,      // Cycle frozen
  output logic                       load_on,        // Load test switch
  output logic                       ee_start,       // Start memory check
  output logic                       ee_pass,        // Check passed
  output logic                       ee_fail,        // Check failed
  output logic                       ser_start,      // Start transmission
  output logic [7:0]                 alarm_byte      // Shown in hex
);
  import csbs_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers and key press detection
  // ----------------------------------------------------------------
  logic [2:0] key_s1;    // First stage, read only by key_s2
  logic [2:0] key_s2;    // Synchronised keys {dec, inc, cal}
  logic [2:0] key_s3;    // Previous value for press edge
  logic [N_ALARM-1:0] alm_s1;  // First stage of alarm pins
  logic [N_ALARM-1:0] alm_s2;  // Synchronised alarms
  wire  [2:0] press = key_s2 & ~key_s3;  // One-cycle press pulses
  wire        cal_p = press[0];
  wire        inc_p = press[1];
  wire        dec_p = press[2];

  // Two flops ahead of any logic, keys bounce-free by the keypad
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      key_s1 <= 3'h0;
      key_s2 <= 3'h0;
      key_s3 <= 3'h0;
      alm_s1 <= '0;
      alm_s2 <= '0;
    end else begin
      key_s1 <= {decrement_key, key_inc, key_cal};
      key_s2 <= key_s1;
      key_s3 <= key_s2;
      alm_s1 <= alarm_in;
      alm_s2 <= alm_s1;
    end
  end

  // ----------------------------------------------------------------
  // One-second tick
  // ----------------------------------------------------------------
  logic sec_tick;  // One pulse per second
  csbs_tick #(.DIV(TICK_DIV)) u_tick (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .tick    (sec_tick)
  );

  // ----------------------------------------------------------------
  // Regulator state machine
  // ----------------------------------------------------------------
  logic [7:0] dly_cnt;  // Seconds since last change, saturating
  wire  boost   = reg_state < ST_FLOAT;
  wire  go_up   = batt_high & ~batt_low;  // Too high: shed banks
  wire  go_down = batt_low & ~batt_high;  // Too low: add banks
  wire  [7:0] dly_lim = accel_test ? ACCEL_DELAY_S : change_delay_s;
  wire  dly_ok  = dly_cnt >= dly_lim;
  wire  normal  = ex_step == EX_OFF;
  wire  [3:0] next_state;
  // boost path sheds bank D first
  assign next_state =
      go_up   ? ((reg_state < ST_FLOAT) ? reg_state + 4'h1 :
                 (reg_state == ST_FLOAT) ? ST_FLOAT : reg_state - 4'h1) :
      go_down ? ((reg_state == ST_ALL_ON) ? ST_ALL_ON :
                 (reg_state < ST_FLOAT) ? reg_state - 4'h1 :
                 (reg_state == ST_LAST) ? ST_ALL_ON : reg_state + 4'h1) :
      reg_state;
  wire  allow   = normal & (boost ? dly_ok : sec_tick);
  wire  change  = allow & (next_state != reg_state);

  // State and delay count; state frozen while exercising the hardware, count keeps running
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      reg_state <= ST_ALL_ON;
      dly_cnt   <= 8'h0;
    end else if (change) begin
      reg_state <= next_state;
      dly_cnt   <= 8'h0;
    end else if (sec_tick && dly_cnt != 8'hff) begin
      dly_cnt <= dly_cnt + 8'h1;
    end
  end

  // ----------------------------------------------------------------
  // Exercise entry sequence
  // ----------------------------------------------------------------
  csbs_seq_t seq;  // Progress through the key sequence
  wire enter = normal & cal_p & (seq == SQ_INC2);
  always_ff @(posedge ref_clk) begin
    if (!rstn || !normal || dec_p) begin
      seq <= SQ_IDLE;
    end else if (cal_p) begin
      seq <= SQ_CAL;
    end else if (inc_p) begin
      seq <= (seq == SQ_CAL)  ? SQ_INC1 :
             (seq == SQ_INC1) ? SQ_INC2 : SQ_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // Exercise cycle
  // ----------------------------------------------------------------
  logic [7:0] dwell;    // Seconds spent in this step
  logic [3:0] sub;      // Bank index or walked state
  logic       ee_seen;  // Memory check answered
  logic       ser_seen; // Transmission finished
  // Step ends after the dwell, never while frozen
  wire  step_end = sec_tick & ~ex_paused & (dwell == DWELL_S - 8'h1);
  wire  last_bank = sub[1:0] == BANK_IDX_D;
  wire  last_walk = sub == ST_LAST;

  // Step sequencing; a decrement press always wins
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ex_step <= EX_OFF;
      sub     <= 4'h0;
      dwell   <= 8'h0;
    end else if (dec_p) begin
      ex_step <= EX_OFF;
    end else if (enter) begin
      ex_step <= EX_BANK;
      sub     <= 4'h0;
      dwell   <= 8'h0;
    end else if (!normal && step_end) begin
      dwell <= 8'h0;
      case (ex_step)
        EX_BANK: begin
          sub     <= last_bank ? 4'h0 : sub + 4'h1;
          ex_step <= last_bank ? EX_LOAD : EX_BANK;
        end
        EX_LOAD: ex_step <= EX_EE;
        EX_EE:   ex_step <= ee_seen ? EX_WALK : EX_EE;
        EX_WALK: begin
          sub     <= last_walk ? 4'h0 : sub + 4'h1;
          ex_step <= last_walk ? EX_SER : EX_WALK;
        end
        EX_SER:  ex_step <= ser_seen ? EX_BANK : EX_SER;
        default: ex_step <= EX_OFF;
      endcase
    end else if (!normal && sec_tick && !ex_paused) begin
      dwell <= dwell + 8'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn || normal || dec_p) begin
      ex_paused <= 1'b0;
    end else if (inc_p) begin
      ex_paused <= ~ex_paused;
    end
  end

  // ----------------------------------------------------------------
  // Memory check and serial transmission handshakes
  // ----------------------------------------------------------------
  wire into_ee  = step_end & (ex_step == EX_LOAD) & ~dec_p;
  wire into_ser = step_end & (ex_step == EX_WALK) & last_walk & ~dec_p;
  // Start pulses are flopped; done may arrive any time in the step
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ee_start  <= 1'b0;
      ser_start <= 1'b0;
      ee_seen   <= 1'b0;
      ser_seen  <= 1'b0;
      ee_pass   <= 1'b0;
      ee_fail   <= 1'b0;
    end else begin
      ee_start  <= into_ee;
      ser_start <= into_ser;
      // Done in the start cycle is kept: ex_step is already EX_EE; outside the step clear wins over set
      ee_seen   <= (ex_step == EX_EE) & (ee_seen | ee_done);
      ser_seen  <= (ex_step == EX_SER) & (ser_seen | ser_done);
      if (ex_step == EX_EE && ee_done) begin
        ee_pass <= ee_ok;
        ee_fail <= ~ee_ok;
      end else if (enter) begin
        ee_pass <= 1'b0;
        ee_fail <= 1'b0;
      end
    end
  end
  // loopback is wired outside; ser_done reports the round trip

  // ----------------------------------------------------------------
  // Flopped outputs: banks, load, alarm byte
  // ----------------------------------------------------------------
  wire [3:0] ex_banks =
      (ex_step == EX_BANK) ? (4'h1 << sub[1:0]) :
      (ex_step == EX_WALK) ? bank_map(sub) : BANKS_NONE;

  // Bank pattern follows the state one cycle later
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      bank_on    <= BANKS_ALL;
      load_on    <= 1'b0;
      alarm_byte <= 8'h0;
    end else begin
      bank_on    <= normal ? bank_map(reg_state) : ex_banks;
      load_on    <= ~normal & (ex_step != EX_BANK);
      alarm_byte <= {1'b0, alm_s2};
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_reset_all_on: assert property (
    @(posedge ref_clk) $rose(rstn) |->
      reg_state == ST_ALL_ON && bank_on == BANKS_ALL)
    else $error("reset did not leave state 0 with all banks on");
  a_boost_waits: assert property (
    @(posedge ref_clk) disable iff (!rstn)
      $past(boost) && $changed(reg_state) |-> $past(dly_ok))
    else $error("boost state changed before delay elapsed");
  a_float_tick: assert property (
    @(posedge ref_clk) disable iff (!rstn)
      !$past(boost) && $changed(reg_state) |-> $past(sec_tick))
    else $error("float state changed without one-second tick");
  a_voltage_cause: assert property (
    @(posedge ref_clk) disable iff (!rstn)
      $changed(reg_state) |-> $past(go_up) || $past(go_down))
    else $error("state changed with voltage in band");
  a_bank_d_first: assert property (
    @(posedge ref_clk) disable iff (!rstn)
      normal && reg_state == 4'h1 ##1 normal |-> bank_on == 4'h7)
    else $error("bank D not first off");
  a_single_bank: assert property (
    @(posedge ref_clk) disable iff (!rstn)
      ex_step == EX_BANK ##1 ex_step == EX_BANK |-> $onehot(bank_on))
    else $error("more than one bank on during bank test");
  a_pause_holds: assert property (
    @(posedge ref_clk) disable iff (!rstn)
      ex_paused && !dec_p |=> $stable(ex_step) && $stable(sub))
    else $error("exercise advanced while paused");
  a_dec_exits: assert property (
    @(posedge ref_clk) disable iff (!rstn)
      dec_p |=> ex_step == EX_OFF ##1 !ex_paused)
    else $error("decrement did not end exercise");
  // Checked against the pins, three flops back, not against alm_s2
  a_alarm_map: assert property (
    @(posedge ref_clk) disable iff (!rstn)
      $past(rstn, 3) && $past(rstn, 2) && $past(rstn) |->
        alarm_byte == {1'b0, $past(alarm_in, 3)})
    else $error("alarm byte mapping wrong");
  a_ee_result: assert property (
    @(posedge ref_clk) disable iff (!rstn)
      ex_step == EX_EE && ee_done |=> ee_pass == $past(ee_ok)
        && ee_fail == !$past(ee_ok))
    else $error("memory check result not latched");
  // Two seconds must be enough, whatever the configured delay
  a_accel_two: assert property (
    @(posedge ref_clk) disable iff (!rstn)
      accel_test && boost && normal && dly_cnt >= 8'h02 &&
        next_state != reg_state |=> reg_state == $past(next_state))
    else $error("accelerated delay not two seconds");
endmodule
`default_nettype wire

//--- logic/csbs_tick.sv
// One-second enable pulse divided down from ref_clk
`timescale 1ns/1ps
`default_nettype none
module csbs_tick #(
  parameter int unsigned DIV = 25_000_000  // Clock cycles per tick
) (
  input  wire logic ref_clk,   // 25 MHz clock
  input  wire logic rstn,      // Synchronous reset, active low
  output logic      tick       // One-cycle pulse each DIV cycles
);
  // ----------------------------------------------------------------
  // Free running divider
  // ----------------------------------------------------------------
  logic [31:0] cnt;  // Cycles since last tick
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cnt  <= 32'h0;
      tick <= 1'b0;
    end else if (cnt == DIV[31:0] - 32'h1) begin
      cnt  <= 32'h0;
      tick <= 1'b1;
    end else begin
      cnt  <= cnt + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire
